// *** slpx_consts.svh ***
// constants for the sleep exit and pin hold controller
`ifndef SLPX_CONSTS_SVH
`define SLPX_CONSTS_SVH
`define SLPX_ADDR_RESET_CAUSE 12'h000
`define SLPX_ADDR_SLEEP_CAUSE 12'h004
`define SLPX_ADDR_SCRATCH 12'h008
`define SLPX_ADDR_HOLD 12'h00C
`define SLPX_ADDR_CONFIG 12'h010
`define SLPX_ADDR_CONTROL 12'h014
`define SLPX_ADDR_IRQ_STATUS 12'h018
`define SLPX_ADDR_IRQ_CLEAR 12'h01C
`define SLPX_ADDR_IRQ_ENABLE 12'h020
`define SLPX_ADDR_STATE 12'h024
`define SLPX_RC_SLEEP 0
`define SLPX_RC_SOFT 1
`define SLPX_RC_WDOG 2
`define SLPX_RC_HW 3
`define SLPX_SC_CORE 0
`define SLPX_SC_BATT 1
`define SLPX_SC_FORCE 2
`define SLPX_HOLD_DRAM 0
`define SLPX_HOLD_PERIPH 1
`define SLPX_CFG_FLOAT_STATIC 2
`define SLPX_CFG_FLOAT_CARD 1
`define SLPX_CFG_PERIPH_ZERO 4
`define SLPX_CTL_FORCE 0
`define SLPX_CTL_SOFT_RESET 1
`define SLPX_IRQ_WAKE 0
`define SLPX_IRQ_SLEEP 1
`define SLPX_IRQ_HWRST 2
`define SLPX_CLK_HZ 100000000
`define SLPX_TICK_HZ 32768
`define SLPX_TICK_DIV (`SLPX_CLK_HZ / `SLPX_TICK_HZ)
`define SLPX_PLL_LOCK_TICKS 4
`endif

// *** slpx_far_side.sv ***
// far-side model: i/o supply ramp and external hardware reset pin
`timescale 1ns/100ps
`default_nettype none
module slpx_far_side #(
  parameter int RAMP = 40,
  parameter int PULSE = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pulse_hw,
  output logic io_supply_good,
  output logic external_hw_reset_n
);
  int ramp_reg, pulse_reg;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ramp_reg <= 0;
      pulse_reg <= 0;
    end
    else
    begin
      ramp_reg <= (ramp_reg < RAMP) ? ramp_reg + 1 : ramp_reg;
      pulse_reg <= pulse_hw ? PULSE : ((pulse_reg > 0) ? pulse_reg - 1 : 0);
    end
  // slow rail: the block has to wait for it before enabling the core
  assign io_supply_good = (ramp_reg == RAMP);
  // pin stays released in sleep unless a pulse is asked for
  assign external_hw_reset_n = (pulse_reg == 0);
endmodule
`default_nettype wire

// *** slpx_monitor.sv ***
// assertion checker for the sleep exit and pin hold controller
`include "slpx_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module slpx_monitor #(
  parameter int PER_W = 8,
  parameter int STR_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic external_hw_reset_n,
  input wire logic io_supply_good,
  input wire logic core_supply_en,
  input wire logic internal_reset_n,
  input wire logic sleep_active,
  input wire logic [STR_W-1:0] dram_row_strobe_cs,
  input wire logic [31:0] ctl_bus_out,
  input wire logic [31:0] bus_out,
  input wire logic sdram_row_cmd,
  input wire logic ctl_sdram_row_cmd,
  input wire logic [5:0] static_cs_n,
  input wire logic [PER_W-1:0] per_pin_out
);
  // ----------------------------------------------------------------
  // hold tracking: cleared at sleep entry, set by a clearing write
  // ----------------------------------------------------------------
  logic sleep_q, dram_free_reg, per_free_reg;
  wire hold_wr = psel & penable & pready & pwrite & (paddr == `SLPX_ADDR_HOLD);
  wire entering = sleep_active & ~sleep_q;
  // a hardware reset in sleep loses all context, so both holds go
  wire dram_free_next = ~external_hw_reset_n | (hold_wr & pwdata[0]) | (dram_free_reg & ~entering);
  wire per_free_next = ~external_hw_reset_n | (hold_wr & pwdata[1]) | (per_free_reg & ~entering);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {sleep_q, dram_free_reg, per_free_reg} <= 3'b011;
    else
      {sleep_q, dram_free_reg, per_free_reg} <= {sleep_active, dram_free_next, per_free_next};
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_core_en_gated: assert property (!io_supply_good |=> !core_supply_en)
    else $error("core supply enabled without io supply");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_sleep_low_pins: assert property (sleep_active && $past(sleep_active) |->
    bus_out == 32'h0 && dram_row_strobe_cs == '0) else $error("low pins not low in sleep");
  a_sleep_high_pins: assert property (sleep_active && $past(sleep_active) |->
    sdram_row_cmd && static_cs_n == 6'h3F) else $error("high pins not high in sleep");
  a_dram_held: assert property (!dram_free_reg |-> dram_row_strobe_cs == '0)
    else $error("dram strobes released while held");
  a_per_held: assert property (!per_free_reg |-> per_pin_out == '0)
    else $error("peripheral pins released while held");
  a_run_drives: assert property (internal_reset_n && $past(internal_reset_n) |->
    bus_out == $past(ctl_bus_out) && sdram_row_cmd == $past(ctl_sdram_row_cmd))
    else $error("pins not driven normally in run");
  a_hw_reset_holds: assert property (!external_hw_reset_n |=> !internal_reset_n)
    else $error("internal reset released during hardware reset");
endmodule
bind slpx_top slpx_monitor #(.PER_W(PER_W), .STR_W(STR_W)) slpx_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .external_hw_reset_n(external_hw_reset_n),
  .io_supply_good(io_supply_good), .core_supply_en(core_supply_en),
  .internal_reset_n(internal_reset_n), .sleep_active(sleep_active),
  .dram_row_strobe_cs(dram_row_strobe_cs), .ctl_bus_out(ctl_bus_out), .bus_out(bus_out),
  .sdram_row_cmd(sdram_row_cmd), .ctl_sdram_row_cmd(ctl_sdram_row_cmd),
  .static_cs_n(static_cs_n), .per_pin_out(per_pin_out)
);
`default_nettype wire

// *** slpx_pkg.sv ***
// types for the sleep exit and pin hold controller
package slpx_pkg;
  typedef enum logic [4:0] {
    SLPX_RUN = 5'h01,
    SLPX_SLEEP = 5'h02,
    SLPX_SUPPLY = 5'h04,
    SLPX_LOCK = 5'h08,
    SLPX_BOOT = 5'h10
  } slpx_state_t;
endpackage

// *** slpx_tick.sv ***
// divider producing the 32.768 kHz one-cycle enable
`timescale 1ns/100ps
`default_nettype none
module slpx_tick #(
  parameter int DIV = 3051
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  logic [15:0] cnt_reg;
  wire logic wrap = (cnt_reg == 16'(DIV - 1));
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= 16'h0000;
      tick <= 1'b0;
    end
    else
    begin
      cnt_reg <= wrap ? 16'h0000 : cnt_reg + 16'h0001;
      tick <= wrap;
    end
  end
endmodule
`default_nettype wire

// *** slpx_top.sv ***
// sleep exit sequencer, cause status, scratch and sleep pin holding
//
// Operation
// - reset cause register flags sleep, software, watchdog and hardware reset
// - sticky sleep causes core fault, battery fault, forced sleep until cleared
// - scratch word written by software, kept through sleep, never interpreted
// - hardware reset in sleep clears holds, enables supply, times lock, boots
// - clearing DRAM hold returns DRAM strobes from low to the controller's levels
// - core supply enable stays off until the I/O supply is good
// - class 1 outputs low in sleep, held until DRAM hold cleared
// - class 1b outputs low in sleep, normal right after exit
// - class 2 high in sleep, floated when matching float bit set
// - class 2b high in sleep, normal right after exit
// - class 3 pins hold programmed level as outputs, sampled as inputs
// - class 4 pins inputs in sleep, zero or floated, held until cleared
// - class 8 receivers disabled in sleep
`include "slpx_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module slpx_top #(
  parameter int GP_W = 28,
  parameter int PER_W = 8,
  parameter int STR_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic external_hw_reset_n,
  input wire logic watchdog_reset,
  input wire logic core_supply_fault,
  input wire logic battery_fault,
  input wire logic io_supply_good,
  input wire logic wake_event,
  input wire logic sleep_req,
  output logic core_supply_en,
  output logic internal_reset_n,
  output logic sleep_active,
  input wire logic [STR_W-1:0] ctl_row_strobe_cs,
  input wire logic [STR_W-1:0] ctl_col_strobe_mask,
  output logic [STR_W-1:0] dram_row_strobe_cs,
  output logic [STR_W-1:0] dram_col_strobe_mask,
  input wire logic [31:0] ctl_bus_out,
  input wire logic ctl_bus_oe,
  output logic [31:0] bus_out,
  output logic bus_oe,
  input wire logic [5:0] ctl_static_cs_n,
  output logic [5:0] static_cs_n,
  output logic static_oe,
  input wire logic ctl_card_ctrl_n,
  output logic card_ctrl_n,
  output logic card_oe,
  input wire logic ctl_sdram_row_cmd,
  input wire logic ctl_sdram_col_cmd,
  output logic sdram_row_cmd,
  output logic sdram_col_cmd,
  input wire logic [GP_W-1:0] gp_out,
  input wire logic [GP_W-1:0] gp_dir,
  input wire logic [GP_W-1:0] general_purpose_pin_in,
  output logic [GP_W-1:0] general_purpose_pin_out,
  output logic [GP_W-1:0] general_purpose_pin_oe,
  output logic [GP_W-1:0] gp_sampled,
  input wire logic [PER_W-1:0] per_out,
  input wire logic [PER_W-1:0] per_oe,
  input wire logic [PER_W-1:0] per_pin_in,
  output logic [PER_W-1:0] per_pin_out,
  output logic [PER_W-1:0] per_pin_oe,
  output logic [PER_W-1:0] per_sampled,
  input wire logic debug_in,
  output logic debug_sampled
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  slpx_pkg::slpx_state_t state_reg, state_next;
  logic [3:0] reset_cause_status;
  logic [2:0] sleep_cause_status;
  logic [31:0] sleep_scratch_word;
  logic [1:0] power_status_hold_reg;
  logic [4:0] power_config_reg;
  logic force_sleep_bit;
  logic [2:0] irq_status_reg, irq_enable_reg;
  logic [2:0] lock_cnt_reg;
  logic hw_rst_seen_reg;
  logic tick;

  slpx_tick #(.DIV(`SLPX_TICK_DIV)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  wire logic rd_hit_ok = (paddr <= `SLPX_ADDR_STATE) && (paddr[1:0] == 2'h0);
  wire logic wr_rc = wr && (paddr == `SLPX_ADDR_RESET_CAUSE);
  wire logic wr_sc = wr && (paddr == `SLPX_ADDR_SLEEP_CAUSE);
  wire logic wr_scr = wr && (paddr == `SLPX_ADDR_SCRATCH);
  wire logic wr_hold = wr && (paddr == `SLPX_ADDR_HOLD);
  wire logic wr_cfg = wr && (paddr == `SLPX_ADDR_CONFIG);
  wire logic wr_ctl = wr && (paddr == `SLPX_ADDR_CONTROL);
  wire logic wr_iclr = wr && (paddr == `SLPX_ADDR_IRQ_CLEAR);
  wire logic wr_ien = wr && (paddr == `SLPX_ADDR_IRQ_ENABLE);
  wire logic soft_reset = wr_ctl && pwdata[`SLPX_CTL_SOFT_RESET];
  wire logic force_set = wr_ctl && pwdata[`SLPX_CTL_FORCE];

  logic [31:0] rdata;
  always_comb
  begin
    rdata = 32'h0000_0000;
    case (paddr)
      `SLPX_ADDR_RESET_CAUSE: rdata = {28'h0, reset_cause_status};
      `SLPX_ADDR_SLEEP_CAUSE: rdata = {29'h0, sleep_cause_status};
      `SLPX_ADDR_SCRATCH: rdata = sleep_scratch_word;
      `SLPX_ADDR_HOLD: rdata = {30'h0, power_status_hold_reg};
      `SLPX_ADDR_CONFIG: rdata = {27'h0, power_config_reg};
      `SLPX_ADDR_CONTROL: rdata = {31'h0, force_sleep_bit};
      `SLPX_ADDR_IRQ_STATUS: rdata = {29'h0, irq_status_reg};
      `SLPX_ADDR_IRQ_ENABLE: rdata = {29'h0, irq_enable_reg};
      `SLPX_ADDR_STATE: rdata = {27'h0, state_reg};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  wire logic in_sleep = (state_reg == slpx_pkg::SLPX_SLEEP);
  wire logic fault = core_supply_fault || battery_fault;
  wire logic enter_sleep = force_sleep_bit || sleep_req || fault;
  // a reset pulse seen while asleep makes the exit a full boot
  wire logic hw_exit = hw_rst_seen_reg && external_hw_reset_n;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      slpx_pkg::SLPX_RUN:
        if (enter_sleep)
          state_next = slpx_pkg::SLPX_SLEEP;
      slpx_pkg::SLPX_SLEEP:
        if (hw_exit || (wake_event && !battery_fault))
          state_next = slpx_pkg::SLPX_SUPPLY;
      slpx_pkg::SLPX_SUPPLY:
        if (battery_fault && !hw_rst_seen_reg)
          state_next = slpx_pkg::SLPX_SLEEP;
        else if (io_supply_good)
          state_next = slpx_pkg::SLPX_LOCK;
      slpx_pkg::SLPX_LOCK:
        if (lock_cnt_reg == 3'(`SLPX_PLL_LOCK_TICKS))
          state_next = slpx_pkg::SLPX_BOOT;
      slpx_pkg::SLPX_BOOT:
        state_next = slpx_pkg::SLPX_RUN;
      default:
        state_next = slpx_pkg::SLPX_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= slpx_pkg::SLPX_RUN;
      lock_cnt_reg <= 3'h0;
      hw_rst_seen_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg != slpx_pkg::SLPX_LOCK)
        lock_cnt_reg <= 3'h0;
      else if (tick)
        lock_cnt_reg <= lock_cnt_reg + 3'h1;
      if (in_sleep && !external_hw_reset_n)
        hw_rst_seen_reg <= 1'b1;
      else if (state_reg == slpx_pkg::SLPX_BOOT)
        hw_rst_seen_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // status and control registers
  // ------------------------------------------------------------
  wire logic boot = (state_reg == slpx_pkg::SLPX_BOOT);
  wire logic hw_rst_run = !external_hw_reset_n && !in_sleep;
  wire logic [2:0] sc_evt = {force_sleep_bit || sleep_req, battery_fault, core_supply_fault};
  wire logic [2:0] irq_evt = {boot && hw_rst_seen_reg, in_sleep && state_reg != state_next,
    boot};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_cause_status <= 4'h8;
      sleep_cause_status <= 3'h0;
      sleep_scratch_word <= 32'h0000_0000;
      power_status_hold_reg <= 2'h0;
      power_config_reg <= 5'h00;
      force_sleep_bit <= 1'b0;
      irq_status_reg <= 3'h0;
      irq_enable_reg <= 3'h0;
    end
    else
    begin
      // causes are replaced on each boot; a later write of ones clears
      if (boot)
        reset_cause_status <= hw_rst_seen_reg ? 4'h8 : 4'h1;
      else if (hw_rst_run)
        reset_cause_status <= 4'h8;
      else if (watchdog_reset)
        reset_cause_status <= 4'h4;
      else if (soft_reset)
        reset_cause_status <= 4'h2;
      else if (wr_rc)
        reset_cause_status <= reset_cause_status & ~pwdata[3:0];
      if (state_reg == slpx_pkg::SLPX_RUN && enter_sleep)
        sleep_cause_status <= sleep_cause_status | sc_evt |
          ((wr_sc ? ~pwdata[2:0] : 3'h7) & 3'h0);
      else if (wr_sc)
        sleep_cause_status <= sleep_cause_status & ~pwdata[2:0];
      if (wr_scr)
        sleep_scratch_word <= pwdata;
      if (state_reg == slpx_pkg::SLPX_RUN && enter_sleep)
        power_status_hold_reg <= 2'h3;
      else if (hw_exit)
        power_status_hold_reg <= 2'h0;
      else if (wr_hold)
        power_status_hold_reg <= power_status_hold_reg & ~pwdata[1:0];
      if (wr_cfg)
        power_config_reg <= pwdata[4:0];
      if (in_sleep)
        force_sleep_bit <= 1'b0;
      else if (force_set)
        force_sleep_bit <= 1'b1;
      irq_status_reg <= (irq_status_reg & ~({3{wr_iclr}} & pwdata[2:0])) | irq_evt;
      if (wr_ien)
        irq_enable_reg <= pwdata[2:0];
    end
  end

  // ------------------------------------------------------------
  // pin behaviour in sleep
  // ------------------------------------------------------------
  wire logic dram_hold = power_status_hold_reg[`SLPX_HOLD_DRAM];
  wire logic per_hold = power_status_hold_reg[`SLPX_HOLD_PERIPH];
  wire logic per_freeze = in_sleep || per_hold;
  wire logic fl_static = power_config_reg[`SLPX_CFG_FLOAT_STATIC];
  wire logic fl_card = power_config_reg[`SLPX_CFG_FLOAT_CARD];
  wire logic per_zero = power_config_reg[`SLPX_CFG_PERIPH_ZERO];
  wire logic supply_on = !in_sleep && io_supply_good;
  wire logic [GP_W-1:0] gp_oe_n = gp_dir;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      core_supply_en <= 1'b0;
      internal_reset_n <= 1'b0;
      sleep_active <= 1'b0;
      dram_row_strobe_cs <= '0;
      dram_col_strobe_mask <= '0;
      bus_out <= 32'h0000_0000;
      bus_oe <= 1'b0;
      static_cs_n <= 6'h3F;
      static_oe <= 1'b1;
      card_ctrl_n <= 1'b1;
      card_oe <= 1'b1;
      sdram_row_cmd <= 1'b1;
      sdram_col_cmd <= 1'b1;
      per_pin_out <= '0;
      per_pin_oe <= '0;
      per_sampled <= '0;
      debug_sampled <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !rd_hit_ok;
      prdata <= rdata;
      irq <= |(irq_status_reg & irq_enable_reg);
      core_supply_en <= supply_on;
      internal_reset_n <= (state_reg == slpx_pkg::SLPX_RUN) && external_hw_reset_n;
      sleep_active <= in_sleep;
      // class 1: low while asleep or still held
      dram_row_strobe_cs <= dram_hold ? '0 : ctl_row_strobe_cs;
      dram_col_strobe_mask <= dram_hold ? '0 : ctl_col_strobe_mask;
      // class 1b: low in sleep only
      bus_out <= in_sleep ? 32'h0000_0000 : ctl_bus_out;
      bus_oe <= in_sleep ? 1'b1 : ctl_bus_oe;
      // class 2: high in sleep unless floated
      static_cs_n <= in_sleep ? 6'h3F : ctl_static_cs_n;
      static_oe <= !(in_sleep && fl_static);
      card_ctrl_n <= in_sleep ? 1'b1 : ctl_card_ctrl_n;
      card_oe <= !(in_sleep && fl_card);
      // class 2b: high in sleep only
      sdram_row_cmd <= in_sleep ? 1'b1 : ctl_sdram_row_cmd;
      sdram_col_cmd <= in_sleep ? 1'b1 : ctl_sdram_col_cmd;
      // class 4: receivers off, zero or float, held until released
      per_pin_out <= per_freeze ? '0 : per_out;
      per_pin_oe <= per_freeze ? {PER_W{per_zero}} : per_oe;
      if (!per_freeze)
        per_sampled <= per_pin_in;
      // class 8 debug receiver ignored in sleep
      if (!in_sleep)
        debug_sampled <= debug_in;
    end
  end

  // class 3 general-purpose pins keep level and sampling across sleep
  genvar g;
  generate
    for (g = 0; g < GP_W; g++)
    begin : g_gp
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          general_purpose_pin_out[g] <= 1'b0;
          general_purpose_pin_oe[g] <= 1'b0;
          gp_sampled[g] <= 1'b0;
        end
        else
        begin
          general_purpose_pin_out[g] <= gp_out[g];
          general_purpose_pin_oe[g] <= gp_oe_n[g];
          gp_sampled[g] <= general_purpose_pin_in[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** test_slpx_top.sv ***
// self-checking bench for the sleep exit and pin hold controller
`include "slpx_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module test_slpx_top;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} slpx_note_t;
  localparam logic [11:0] RC = `SLPX_ADDR_RESET_CAUSE, SC = `SLPX_ADDR_SLEEP_CAUSE;
  localparam logic [11:0] SP = `SLPX_ADDR_SCRATCH, HD = `SLPX_ADDR_HOLD, CF = `SLPX_ADDR_CONFIG;
  localparam logic [11:0] CT = `SLPX_ADDR_CONTROL, IC = `SLPX_ADDR_IRQ_CLEAR;
  localparam logic [11:0] IE = `SLPX_ADDR_IRQ_ENABLE;
  logic clk = 0, rstn = 0, sel = 0, en = 0, wr = 0, wdg = 0, cf = 0, bf = 0, wk = 0, sr = 0;
  logic hw = 0, rdy, err, irq, iog, xr_n, cen, ir_n, slp, boe, soe, cd_n, coe, srow, scol, dbs;
  logic [11:0] a = '0;
  logic [31:0] wd = '0, rd, bo;
  logic [42:0] cv = '0;
  logic [107:0] pv = '0;
  logic [3:0] crow = 4'h1, ccol = 4'h1, drow, dcol;
  logic [5:0] scs;
  logic [27:0] gpo, gpe, gps;
  logic [7:0] ppo, ppe, pps;
  logic tg = 0;
  logic [8:0] held;
  slpx_note_t notes[$];
  slpx_note_t nt;
  int n_mismatch = 0, num_checks = 0, k;
  integer seed = 32'hFBE1F194;
  initial forever #5 clk = ~clk;
  slpx_top #(.GP_W(28), .PER_W(8), .STR_W(4)) slpx_top_inst (
    .pclk(clk), .presetn(rstn), .psel(sel), .penable(en), .pwrite(wr), .paddr(a),
    .pwdata(wd), .prdata(rd), .pready(rdy), .pslverr(err), .irq(irq),
    .external_hw_reset_n(xr_n), .watchdog_reset(wdg), .core_supply_fault(cf),
    .battery_fault(bf), .io_supply_good(iog), .wake_event(wk), .sleep_req(sr),
    .core_supply_en(cen), .internal_reset_n(ir_n), .sleep_active(slp),
    .ctl_row_strobe_cs(crow), .ctl_col_strobe_mask(ccol), .dram_row_strobe_cs(drow),
    .dram_col_strobe_mask(dcol), .ctl_bus_out(cv[41:10]), .ctl_bus_oe(cv[9]), .bus_out(bo),
    .bus_oe(boe), .ctl_static_cs_n(cv[8:3]), .static_cs_n(scs), .static_oe(soe),
    .ctl_card_ctrl_n(cv[2]), .card_ctrl_n(cd_n), .card_oe(coe), .ctl_sdram_row_cmd(cv[1]),
    .ctl_sdram_col_cmd(cv[0]), .sdram_row_cmd(srow), .sdram_col_cmd(scol),
    .gp_out(pv[107:80]), .gp_dir(pv[79:52]), .general_purpose_pin_in(pv[51:24]),
    .general_purpose_pin_out(gpo), .general_purpose_pin_oe(gpe), .gp_sampled(gps),
    .per_out(pv[23:16]), .per_oe(pv[15:8]), .per_pin_in(pv[7:0]), .per_pin_out(ppo),
    .per_pin_oe(ppe), .per_sampled(pps), .debug_in(cv[42]), .debug_sampled(dbs)
  );
  slpx_far_side slpx_far_side_inst (.pclk(clk), .presetn(rstn), .pulse_hw(hw),
    .io_supply_good(iog), .external_hw_reset_n(xr_n));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    n_mismatch += (seen !== exp);
    if (seen !== exp) $display("[ERR] %s expected %h seen %h", what, exp, seen);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic hang();
    check(0, 1, "completion");
    summarize();
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] dw,
    input logic [31:0] d = '0, input logic [31:0] m = '0, input logic e = 0);
    notes.push_back(slpx_note_t'{d, m, e});
    @(posedge clk);
    {sel, en, wr, a, wd} <= {1'b1, 1'b0, w, ad, dw};
    @(posedge clk);
    en <= 1'b1;
    k = 0;
    do @(posedge clk); while (rdy !== 1'b1 && ++k < 50);
    {sel, en} <= 2'b00;
    if (k == 50) hang();
  endtask
  task automatic nap();
    repeat (3) @(posedge clk);
  endtask
  task automatic go(input logic s);
    k = 0;
    do @(posedge clk); while ((s ? slp : ir_n) !== 1'b1 && ++k < 30000);
    if (k == 30000) hang();
    else nap();
  endtask
  always @(posedge clk)
    if (rdy === 1'b1 && notes.size() > 0)
    begin
      nt = notes.pop_front();
      check(rd & nt.m, nt.d, "prdata");
      check(err, nt.e, "pslverr");
    end
  // pins stay quiet in sleep to keep the sleep current down
  always @(posedge clk)
    if (!slp)
    begin
      pv <= 108'({$random(seed), $random(seed), $random(seed), $random(seed)});
      cv <= 43'({$random(seed), $random(seed)});
      crow <= 4'($random(seed)) | 4'h1;
      ccol <= 4'($random(seed)) | 4'h1;
    end
    // one deliberate edge in sleep shows which receivers still sample
    else if (tg)
    begin
      pv[51:24] <= ~pv[51:24];
      pv[7:0] <= ~pv[7:0];
      cv[42] <= ~cv[42];
    end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    apb(0, RC, 0, 32'h8, 32'hF);
    apb(0, SC, 0, 0, 32'h7);
    apb(0, 12'h028, 0, 0, 32'hFFFFFFFF, 1);
    apb(1, SP, 32'hA5C30F96);
    wdg <= 1'b1;
    @(posedge clk);
    wdg <= 1'b0;
    apb(1, CT, 32'h2);
    apb(0, RC, 0, 32'h2, 32'hF);
    apb(1, RC, 32'hF);
    apb(1, CF, 32'h16);
    apb(1, IE, 32'h7);
    apb(1, CT, 32'h1);
    go(1);
    check(soe | coe, 0, "floated_oe");
    check(ppe, 8'hFF, "per_zero_oe");
    check({boe, cd_n, scol, dcol, cen}, 8'hE0, "sleep_levels");
    check(gpo, pv[107:80], "gp_out");
    check(gpe, pv[79:52], "gp_oe");
    held = {dbs, pps};
    tg <= 1'b1;
    @(posedge clk);
    tg <= 1'b0;
    nap();
    check({dbs, pps}, held, "frozen_inputs");
    check(gps, pv[51:24], "gp_in");
    wk <= 1'b1;
    go(0);
    wk <= 1'b0;
    check(drow, 0, "dram_row");
    check(ppo, 0, "per_pin_out");
    apb(0, RC, 0, 32'h1, 32'hF);
    apb(0, SC, 0, 32'h4, 32'h7);
    apb(0, SP, 0, 32'hA5C30F96, 32'hFFFFFFFF);
    apb(0, CT, 0, 0, 32'h1);
    check(irq, 1, "irq");
    apb(1, IE, 0);
    nap();
    check(irq, 0, "irq_masked");
    apb(1, IE, 32'h7);
    nap();
    check(irq, 1, "irq_unmasked");
    apb(1, IC, 32'h7);
    nap();
    check(irq, 0, "irq_cleared");
    apb(1, HD, 32'h1);
    nap();
    check(|drow, 1, "dram_released");
    apb(1, HD, 32'h2);
    apb(0, HD, 0, 0, 32'h3);
    apb(1, SC, 32'h7);
    {cf, bf} <= 2'b11;
    go(1);
    {cf, bf} <= 2'b00;
    wk <= 1'b1;
    go(0);
    wk <= 1'b0;
    apb(0, SC, 0, 32'h3, 32'h7);
    apb(1, CF, 0);
    sr <= 1'b1;
    @(posedge clk);
    sr <= 1'b0;
    go(1);
    check(soe & coe, 1, "driven_oe");
    check(ppe, 0, "per_float_oe");
    hw <= 1'b1;
    @(posedge clk);
    hw <= 1'b0;
    go(0);
    check(|drow, 1, "dram_after_hw_reset");
    check(cen, 1, "supply_after_hw_reset");
    apb(0, CT, 0, 0, 32'h1);
    apb(0, RC, 0, 32'h8, 32'h8);
    summarize();
  end
endmodule
`default_nettype wire
